// >>> hw/ilim_cfg.v
// Current-limit sensing configuration and fault qualification
`timescale 1ns/1ps
`default_nettype none
`include "ilim_cfg_defines.vh"
module ilim_cfg (
  // Clock and reset
  input wire CLK_SYS,
  input wire RSTN,
  // Strap measurement from the pin front end (asynchronous)
  input wire STRAP_VALID,
  input wire [1:0] THR_STRAP_KIND,
  input wire [4:0] THR_STRAP_RIDX,
  input wire [1:0] METH_STRAP_KIND,
  input wire [4:0] METH_STRAP_RIDX,
  // Host overrides from the serial link logic (same clock)
  input wire HOST_WR,
  input wire [1:0] HOST_METHOD,
  input wire [5:0] HOST_BLANK,
  input wire [3:0] HOST_VIOL,
  input wire [1:0] HOST_ACTION,
  input wire [6:0] HOST_VLIM,
  input wire FAULT_CLR,
  // Switching phase (same clock) and comparators (asynchronous)
  input wire LS_ON,
  input wire SENSE_OVER,
  input wire SENSE_UNDER,
  // Configuration in force
  output reg CFG_VALID,
  output reg [1:0] METHOD,
  output reg [5:0] BLANK_CYC,
  output reg [3:0] VIOL_LIMIT,
  output reg [6:0] VLIM_MV,
  output reg [1:0] FAULT_ACTION,
  // Sampling and fault status
  output reg SAMPLE_EN,
  output reg [4:0] VIOL_CNT,
  output reg OC_FAULT,
  output reg UC_FAULT
);

  localparam SW = 17;

  wire [SW-1:0] async_in;
  wire [SW-1:0] sync_out;
  wire strap_valid_s;
  wire [1:0] thr_kind;
  wire [4:0] thr_ridx;
  wire [1:0] meth_kind;
  wire [4:0] meth_ridx;
  wire over_s;
  wire under_s;

  assign async_in = {STRAP_VALID, THR_STRAP_KIND, THR_STRAP_RIDX,
                     METH_STRAP_KIND, METH_STRAP_RIDX, SENSE_OVER,
                     SENSE_UNDER};

  // All pin-side inputs pass two flip-flops
  strap_sync #(.W(SW)) u_sync (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .d(async_in),
    .q(sync_out)
  );

  assign {strap_valid_s, thr_kind, thr_ridx, meth_kind, meth_ridx,
          over_s, under_s} = sync_out;

  // Strap decode
  reg thr_res_ok;
  reg meth_res_ok;
  reg [1:0] dec_method;
  reg [3:0] dec_viol;
  reg [6:0] dec_vlim;
  reg [6:0] grid_idx;

  always @* begin
    thr_res_ok = (thr_kind == `KIND_RES) &&
                 (thr_ridx >= `RIDX_THR_MIN) &&
                 (thr_ridx <= `RIDX_THR_MAX);
    meth_res_ok = (meth_kind == `KIND_RES) &&
                  (meth_ridx <= `RIDX_METH_LAST);
    grid_idx = `VLIM_ROW * {5'h00, meth_kind} + {5'h00, thr_kind};
    dec_method = `METH_RDS;
    dec_viol = `VIOL_STRAP;
    if (meth_res_ok) begin
      // Table of eight odd counts per method
      dec_method = meth_ridx[4:3];
      dec_viol = {meth_ridx[2:0], 1'b1};
    end else if (thr_res_ok) begin
      case (meth_kind)
        `KIND_LOW: dec_method = `METH_RDS;
        `KIND_OPEN: dec_method = `METH_DOWN;
        `KIND_HIGH: dec_method = `METH_UP;
        default: dec_method = `METH_RDS;
      endcase
      dec_viol = `VIOL_STRAP;
    end
    // Threshold voltage selection
    if (thr_kind == `KIND_RES) begin
      if (thr_ridx <= `RIDX_VLIM_LAST) begin
        dec_vlim = `VLIM_RES_STEP * {2'h0, thr_ridx};
      end else begin
        dec_vlim = `VLIM_MAX;
      end
    end else if (meth_kind != `KIND_RES) begin
      dec_vlim = `VLIM_GRID_BASE + `VLIM_GRID_STEP * grid_idx;
    end else begin
      dec_vlim = `VLIM_DEF;
    end
  end

  // Blanking length belonging to a method
  function [5:0] blank_of;
    input [1:0] m;
    begin
      case (m)
        `METH_RDS: blank_of = `BLANK_RDS_CYC;
        `METH_DOWN: blank_of = `BLANK_DCR_CYC;
        `METH_UP: blank_of = `BLANK_DCR_CYC;
        default: blank_of = `BLANK_RDS_CYC;
      endcase
    end
  endfunction

  // Configuration: strap latch once, host override any time after
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      CFG_VALID <= 1'b0;
      METHOD <= `METH_RDS;
      BLANK_CYC <= `BLANK_RDS_CYC;
      VIOL_LIMIT <= `VIOL_STRAP;
      VLIM_MV <= `VLIM_DEF;
      FAULT_ACTION <= `ACT_DEF;
    end else if (HOST_WR) begin
      CFG_VALID <= 1'b1;
      METHOD <= HOST_METHOD;
      BLANK_CYC <= HOST_BLANK;
      VIOL_LIMIT <= HOST_VIOL;
      VLIM_MV <= HOST_VLIM;
      FAULT_ACTION <= HOST_ACTION;
    end else if (strap_valid_s && !CFG_VALID) begin
      CFG_VALID <= 1'b1;
      METHOD <= dec_method;
      BLANK_CYC <= blank_of(dec_method);
      VIOL_LIMIT <= dec_viol;
      VLIM_MV <= dec_vlim;
    end
  end

  // Sensing window: low-side phase, or high-side phase for up-slope
  reg window;
  reg window_prev_reg;
  reg [5:0] blank_reg;
  reg taken_reg;

  // Window follows the switch phase that carries the sensed slope
  always @* begin
    window = 1'b0;
    if (CFG_VALID) begin
      case (METHOD)
        `METH_UP: window = !LS_ON;
        `METH_DOWN: window = LS_ON;
        default: window = LS_ON;
      endcase
    end
  end

  // Blank counter, one sample per window after blanking ends
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      window_prev_reg <= 1'b0;
      blank_reg <= 6'h00;
      taken_reg <= 1'b0;
      SAMPLE_EN <= 1'b0;
    end else begin
      window_prev_reg <= window;
      SAMPLE_EN <= 1'b0;
      if (window && !window_prev_reg) begin
        blank_reg <= BLANK_CYC;
        taken_reg <= 1'b0;
      end else if (window) begin
        if (blank_reg != 6'h00) begin
          blank_reg <= blank_reg - 6'h01;
        end else if (!taken_reg) begin
          SAMPLE_EN <= 1'b1;
          taken_reg <= 1'b1;
        end
      end
    end
  end

  // Consecutive violation counter and fault flags
  wire viol_now;
  wire trip;
  wire [4:0] limit_ext;

  assign viol_now = over_s || under_s;
  assign limit_ext = {1'b0, VIOL_LIMIT};
  assign trip = SAMPLE_EN && viol_now && (VIOL_CNT >= limit_ext);

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      VIOL_CNT <= 5'h00;
      OC_FAULT <= 1'b0;
      UC_FAULT <= 1'b0;
    end else begin
      if (SAMPLE_EN) begin
        if (!viol_now) begin
          VIOL_CNT <= 5'h00;
        end else if (VIOL_CNT <= limit_ext) begin
          VIOL_CNT <= VIOL_CNT + 5'h01;
        end
      end
      // Set wins over a clear in the same cycle
      if (trip && over_s) begin
        OC_FAULT <= 1'b1;
      end else if (FAULT_CLR) begin
        OC_FAULT <= 1'b0;
      end
      if (trip && under_s) begin
        UC_FAULT <= 1'b1;
      end else if (FAULT_CLR) begin
        UC_FAULT <= 1'b0;
      end
    end
  end

endmodule // ilim_cfg
`default_nettype wire

// >>> hw/ilim_cfg_defines.vh
// Constants for the current-limit sensing configuration block
`ifndef ILIM_CFG_DEFINES_VH
`define ILIM_CFG_DEFINES_VH

// Clock period and blanking times in ns
`define CLK_PERIOD_NS 40
`define BLANK_RDS_NS 672
`define BLANK_DCR_NS 352
// Blanking in whole clock cycles, rounded up so it is never shorter
`define BLANK_RDS_CYC 6'h11
`define BLANK_DCR_CYC 6'h09
`define BLANK_W 6

// Strap pin kinds reported by the pin-measurement front end
`define KIND_LOW 2'h0
`define KIND_OPEN 2'h1
`define KIND_HIGH 2'h2
`define KIND_RES 2'h3

// Sensing methods
`define METH_RDS 2'h0
`define METH_DOWN 2'h1
`define METH_UP 2'h2

// Resistor table indices (10k is index 0, 100k is index 24)
`define RIDX_W 5
`define RIDX_THR_MIN 5'h01
`define RIDX_THR_MAX 5'h18
`define RIDX_METH_LAST 5'h17
`define RIDX_VLIM_LAST 5'h14

// Violation counts
`define VIOL_W 4
`define VIOL_STRAP 4'h4
`define CNT_W 5

// Threshold voltage in mV
`define VLIM_W 7
`define VLIM_GRID_BASE 7'h14
`define VLIM_GRID_STEP 7'h0A
`define VLIM_RES_STEP 7'h05
`define VLIM_ROW 7'h03
`define VLIM_MAX 7'h64
`define VLIM_DEF 7'h32

// Fault action codes
`define ACT_W 2
`define ACT_DEF 2'h0

`endif

// >>> hw/strap_sync.v
// Two-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module strap_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Asynchronous input and synchronised output
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule // strap_sync
`default_nettype wire

// >>> test/ilim_cfg_props.sv
// Concurrent checks on the current-limit configuration block
`timescale 1ns/1ps
`default_nettype none
module ilim_props (
  // Clock, reset and one-bit ports
  input wire logic CLK_SYS, RSTN, HOST_WR, LS_ON, CFG_VALID,
  input wire logic SAMPLE_EN, OC_FAULT, UC_FAULT,
  // Multi-bit ports
  input wire logic [1:0] HOST_METHOD, HOST_ACTION, METHOD, FAULT_ACTION,
  input wire logic [1:0] THR_STRAP_KIND, METH_STRAP_KIND,
  input wire logic [5:0] HOST_BLANK, BLANK_CYC,
  input wire logic [3:0] HOST_VIOL, VIOL_LIMIT,
  input wire logic [6:0] HOST_VLIM, VLIM_MV,
  input wire logic [4:0] VIOL_CNT
);
  logic win_q;
  logic [7:0] age_reg;
  logic [5:0] blank_q;
  wire win = CFG_VALID & ((METHOD == 2'h2) ? !LS_ON : LS_ON);
  // Cycles since the sampling window opened
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      win_q <= 1'b0;
      age_reg <= 8'h00;
      blank_q <= 6'h00;
    end else begin
      win_q <= win;
      if (win && !win_q)
        blank_q <= BLANK_CYC;
      age_reg <= (win && !win_q) ? 8'h01 : age_reg + {7'h00, win};
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  property strap_p(c);
    $rose(CFG_VALID) && !$past(HOST_WR) |-> c;
  endproperty
  chk_sample_delay: assert property (SAMPLE_EN |-> age_reg == {2'h0, blank_q} + 8'h02)
    else $error("sample not at end of blanking");
  chk_sample_pulse: assert property (SAMPLE_EN |=> !SAMPLE_EN)
    else $error("sample longer than one cycle");
  chk_host_load: assert property (HOST_WR |=> CFG_VALID && METHOD == $past(HOST_METHOD) && VLIM_MV == $past(HOST_VLIM))
    else $error("host method not loaded");
  chk_host_rest: assert property (HOST_WR |=> BLANK_CYC == $past(HOST_BLANK) && VIOL_LIMIT == $past(HOST_VIOL) && FAULT_ACTION == $past(HOST_ACTION))
    else $error("host settings not loaded");
  chk_cfg_hold: assert property (CFG_VALID && !HOST_WR |=> $stable(METHOD) && $stable(BLANK_CYC) && $stable(VIOL_LIMIT))
    else $error("config changed without host write");
  chk_strap_blank: assert property (strap_p(BLANK_CYC == ((METHOD == 2'h0) ? 6'h11 : 6'h09)))
    else $error("strap blanking wrong");
  chk_strap_viol: assert property (strap_p(METH_STRAP_KIND == 2'h3 || VIOL_LIMIT == 4'h4))
    else $error("strap violation count wrong");
  chk_strap_default: assert property (strap_p(THR_STRAP_KIND == 2'h3 || METH_STRAP_KIND == 2'h3 || METHOD == 2'h0))
    else $error("default method wrong");
  chk_fault_qual: assert property ($rose(OC_FAULT) || $rose(UC_FAULT) |-> $past(SAMPLE_EN) && $past(VIOL_CNT) >= $past(VIOL_LIMIT))
    else $error("fault raised too early");
  cov_sample: cover property (SAMPLE_EN);
  cov_over: cover property ($rose(OC_FAULT));
  cov_under: cover property ($rose(UC_FAULT));
endmodule // ilim_props
bind ilim_cfg ilim_props u_ilim_props (.*);
`default_nettype wire

// >>> test/pwr_stage.sv
// Behavioural power stage: low-side switch phase and current comparators
`timescale 1ns/1ps
`default_nettype none
module pwr_stage (
  // Clock and commanded behaviour
  input wire logic clk,
  input wire logic [5:0] on_len,
  input wire logic [5:0] off_len,
  input wire logic over,
  input wire logic under,
  // Switch phase and comparator levels
  output var logic ls_on,
  output var logic sense_over,
  output var logic sense_under
);
  logic [6:0] ph_reg = 7'h00;
  initial ls_on = 1'b0;
  // Fixed switching period, low-side switch on first, changed after the edge
  always @(posedge clk) begin
    ph_reg <= #1 (ph_reg == on_len + off_len - 7'h01) ? 7'h00 : ph_reg + 7'h01;
    ls_on <= #1 (ph_reg < {1'b0, on_len});
  end
  // Comparators report the commanded over and under levels
  assign sense_over = over;
  assign sense_under = under;
endmodule // pwr_stage
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the current-limit configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic CLK_SYS = 1'b0, RSTN = 1'b0, STRAP_VALID = 1'b0, HOST_WR = 1'b0;
  logic FAULT_CLR = 1'b0, over = 1'b0, under = 1'b0;
  logic LS_ON, SENSE_OVER, SENSE_UNDER, CFG_VALID, SAMPLE_EN, OC_FAULT, UC_FAULT;
  logic [1:0] THR_STRAP_KIND = 2'h0, METH_STRAP_KIND = 2'h0;
  logic [1:0] HOST_METHOD = 2'h0, HOST_ACTION = 2'h0, METHOD, FAULT_ACTION;
  logic [4:0] THR_STRAP_RIDX = 5'h00, METH_STRAP_RIDX = 5'h00, VIOL_CNT;
  logic [5:0] HOST_BLANK = 6'h00, BLANK_CYC;
  logic [3:0] HOST_VIOL = 4'h0, VIOL_LIMIT;
  logic [6:0] HOST_VLIM = 7'h00, VLIM_MV;
  int num_errors = 0, checks = 0, cyc = 0;
  always #20 CLK_SYS = ~CLK_SYS;
  ilim_cfg u_ilim_cfg (.*);
  pwr_stage u_pwr_stage (.clk(CLK_SYS), .on_len(6'h0C), .off_len(6'h08),
    .over(over), .under(under), .ls_on(LS_ON), .sense_over(SENSE_OVER),
    .sense_under(SENSE_UNDER));
  // Verdict and end of run
  task report_and_stop;
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop;
    end
  end
  task chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", n, e, s);
    end
  endtask
  // Reset with given straps, then latch them; exp is method,count,blank,mV
  task strap(input logic [1:0] tk, input logic [4:0] ti,
             input logic [1:0] mk, input logic [4:0] mi, input logic [18:0] x);
    RSTN = 1'b0;
    STRAP_VALID = 1'b0;
    {THR_STRAP_KIND, THR_STRAP_RIDX, METH_STRAP_KIND, METH_STRAP_RIDX} = {tk, ti, mk, mi};
    repeat (16) @(posedge CLK_SYS);
    chk("reset", {CFG_VALID, METHOD, VIOL_LIMIT, BLANK_CYC, VLIM_MV}, {1'b0, 2'h0, 4'h4, 6'h11, 7'h32});
    #1 RSTN = 1'b1;
    STRAP_VALID = 1'b1;
    repeat (4) @(posedge CLK_SYS);
    #1 chk("strap", {CFG_VALID, METHOD, VIOL_LIMIT, BLANK_CYC, VLIM_MV}, {1'b1, x});
  endtask
  task host(input logic [1:0] m, a, input logic [5:0] b, input logic [3:0] v,
            input logic [6:0] vl);
    {HOST_METHOD, HOST_ACTION, HOST_BLANK, HOST_VIOL, HOST_VLIM} = {m, a, b, v, vl};
    HOST_WR = 1'b1;
    @(posedge CLK_SYS);
    #1 HOST_WR = 1'b0;
    chk("host", {CFG_VALID, METHOD, FAULT_ACTION, BLANK_CYC, VIOL_LIMIT, VLIM_MV}, {1'b1, m, a, b, v, vl});
  endtask
  // Wait for n sample pulses, then one more edge for the count to land
  task samples(input int n);
    repeat (n) do begin
      @(posedge CLK_SYS);
      #1;
    end while (SAMPLE_EN !== 1'b1);
    @(posedge CLK_SYS);
    #1;
  endtask
  // Main sequence
  initial begin
    strap(2'h3, 5'h05, 2'h0, 5'h00, {2'h0, 4'h4, 6'h11, 7'h19});
    strap(2'h3, 5'h05, 2'h1, 5'h00, {2'h1, 4'h4, 6'h09, 7'h19});
    strap(2'h3, 5'h05, 2'h2, 5'h00, {2'h2, 4'h4, 6'h09, 7'h19});
    strap(2'h1, 5'h00, 2'h2, 5'h00, {2'h0, 4'h4, 6'h11, 7'h5A});
    strap(2'h3, 5'h00, 2'h2, 5'h00, {2'h0, 4'h4, 6'h11, 7'h00});
    strap(2'h3, 5'h18, 2'h1, 5'h00, {2'h1, 4'h4, 6'h09, 7'h64});
    strap(2'h1, 5'h00, 2'h3, 5'h0D, {2'h1, 4'hB, 6'h09, 7'h32});
    strap(2'h0, 5'h00, 2'h3, 5'h17, {2'h2, 4'hF, 6'h09, 7'h32});
    {THR_STRAP_KIND, METH_STRAP_KIND} = {2'h3, 2'h0};
    repeat (4) @(posedge CLK_SYS);
    #1 chk("relatch", METHOD, 2'h2);
    host(2'h0, 2'h2, 6'h03, 4'h1, 7'h28);
    do @(posedge CLK_SYS); while (LS_ON !== 1'b0);
    #1 over = 1'b1;
    samples(1);
    chk("first", {OC_FAULT, VIOL_CNT}, {1'b0, 5'h01});
    samples(1);
    chk("second", {OC_FAULT, VIOL_CNT}, {1'b1, 5'h02});
    over = 1'b0;
    samples(1);
    chk("clear", {OC_FAULT, VIOL_CNT}, {1'b1, 5'h00});
    FAULT_CLR = 1'b1;
    @(posedge CLK_SYS);
    #1 FAULT_CLR = 1'b0;
    chk("fault clear", OC_FAULT, 1'b0);
    host(2'h2, 2'h1, 6'h00, 4'h0, 7'h50);
    do @(posedge CLK_SYS); while (LS_ON !== 1'b1);
    #1 under = 1'b1;
    samples(1);
    chk("under", {UC_FAULT, VIOL_CNT}, {1'b1, 5'h01});
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
